// file: rtl/uart_data_and_status_regs.v
// What this block does
// - One data address: write transmits, read receives
// - Short characters: tx ignores, rx zeroes upper bits
// - Data write while buffer full is dropped
// - Enabled transmitter loads empty shifter, shifts out
// - Two-entry receive FIFO pops on data-port read when not empty
// - Status register at own offset, resets 0x20
// - Rx complete tracks FIFO; rx disable flushes
// - Tx complete sets after frame if buffer empty; ack or one clears
// - Buffer empty flag means writable, reset high
// - Frame error flag follows head stop bit
// - Overrun when FIFO full, hold stage full, start
// - Parity error flag follows head character
// - Double speed picks prescale eight, async only
// - Multiprocessor mode drops frames without address
// - Error, speed, multiprocessor bits dead in SPI
// - Three flags each raise own interrupt request
// - Divider value plus one times prescale sets rate
// - Request needs own enable, global enable, flag
//
// The implementer's own choice: the strobed register port.
`include "uart_data_and_status_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module uart_data_and_status_regs (
   input  wire       clock_in,
   input  wire       rstn_in,
   input  wire [7:0] addr_in,
   input  wire [7:0] wr_data_in,
   input  wire       wr_en_in,
   input  wire       rd_en_in,
   output reg  [7:0] rd_data_out,
   input  wire       serial_receive_pin_in,
   output reg        serial_transmit_pin_out,
   output reg        tx_drive_out,
   input  wire       global_irq_enable_in,
   input  wire       tx_complete_irq_ack_in,
   output reg        rx_complete_irq_out,
   output reg        tx_complete_irq_out,
   output reg        tx_empty_irq_out
);
   localparam R_IDLE = 3'h1;
   localparam R_RECV = 3'h2;
   localparam R_DONE = 3'h4;
   localparam T_IDLE = 2'h1;
   localparam T_SEND = 2'h2;

   reg        rst_meta;
   reg        rstn;
   reg        rx_meta;
   reg        rx_sync;
   reg  [7:0] serial_control_b;
   reg  [7:0] serial_control_c;
   reg  [11:0] baud_divider_value;
   reg        tx_complete_flag;
   reg        double_speed_select;
   reg        multiproc_filter_mode;
   reg        overrun_flag;
   reg  [11:0] baud_cnt;
   reg        tick;
   reg  [10:0] fifo_mem [0:1];
   reg        fifo_wr_ptr;
   reg        fifo_rd_ptr;
   reg  [1:0] fifo_count;
   reg  [10:0] rx_hold;
   reg        rx_hold_valid;
   reg  [2:0] rx_state;
   reg  [4:0] rx_sc;
   reg  [3:0] rx_pos;
   reg  [8:0] rx_shift;
   reg        rx_par_err;
   reg        rx_frm_err;
   reg  [8:0] transmit_buffer;
   reg        tx_buf_valid;
   reg  [1:0] tx_state;
   reg  [8:0] tx_shift;
   reg  [4:0] tx_sc;
   reg  [3:0] tx_pos;
   reg        tx_par;
   reg        tx_stop2;

   wire       spi_mode;
   wire       dbl_eff;
   wire [4:0] spb;
   wire [2:0] size_code;
   wire [3:0] nbits;
   wire       par_en;
   wire       rx_en;
   wire       tx_en;
   wire       tx_buffer_empty_flag;
   wire       rx_complete_flag;
   wire [10:0] head;
   wire       data_rd;
   wire       pop;
   wire       wr_status;
   wire       wr_data;
   wire       tx_load;
   wire       tx_end;
   wire       rx_start;
   wire       rx_push;
   wire       is_addr;
   wire [3:0] rx_last;
   wire [3:0] tx_last;
   wire       tx_bit;
   wire       rx_par_calc;
   wire [7:0] status_rd;
   wire [7:0] next_rd_data;
   wire       next_txc;

   // Reset release through two flops
   always @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta <= 1'b0;
         rstn     <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rstn     <= rst_meta;
      end
   end

   // Receive pin synchroniser
   always @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else begin
         rx_meta <= serial_receive_pin_in;
         rx_sync <= rx_meta;
      end
   end

   // Frame format decode
   assign spi_mode  = (serial_control_c[7:6] == `MODE_MASTER_SPI);
   assign dbl_eff   = double_speed_select & ~spi_mode &
                      (serial_control_c[7:6] == `MODE_ASYNC);
   assign spb       = dbl_eff ? `SAMPLES_DOUBLE : `SAMPLES_NORMAL;
   assign size_code = {serial_control_b[`BIT_SIZE_HIGH],
                       serial_control_c[`BIT_SIZE_MID],
                       serial_control_c[`BIT_SIZE_LOW]};
   assign nbits     = (size_code == 3'h7) ? 4'h9 :
                      size_code[2] ? 4'h8 :
                      (4'h5 + {2'h0, size_code[1:0]});
   assign par_en    = serial_control_c[`BIT_PARITY_ENABLE] & ~spi_mode;
   assign rx_en     = serial_control_b[`BIT_RX_ENABLE];
   assign tx_en     = serial_control_b[`BIT_TX_ENABLE];
   assign rx_last   = nbits + {3'h0, par_en} + 4'h1;
   assign tx_last   = nbits + {3'h0, par_en} + {3'h0, tx_stop2} + 4'h1;

   // Bus decode
   assign wr_status = wr_en_in & (addr_in == `OFS_SERIAL_STATUS_A);
   assign wr_data   = wr_en_in & (addr_in == `OFS_SERIAL_DATA_PORT);
   assign data_rd   = rd_en_in & (addr_in == `OFS_SERIAL_DATA_PORT);
   assign pop       = data_rd & (fifo_count != 2'h0);

   // Flags
   assign tx_buffer_empty_flag = ~tx_buf_valid;
   assign rx_complete_flag     = (fifo_count != 2'h0);
   assign head = fifo_mem[fifo_rd_ptr];
   assign status_rd = {rx_complete_flag,
                       tx_complete_flag,
                       tx_buffer_empty_flag,
                       head[10] & rx_complete_flag & ~spi_mode,
                       overrun_flag & ~spi_mode,
                       head[9] & rx_complete_flag & ~spi_mode,
                       double_speed_select & ~spi_mode,
                       multiproc_filter_mode & ~spi_mode};

   // Registered read data, one cycle after the strobe
   assign next_rd_data =
      (addr_in == `OFS_SERIAL_STATUS_A)   ? status_rd :
      (addr_in == `OFS_SERIAL_CONTROL_B)  ? {serial_control_b[7:2],
                                             head[8] & rx_complete_flag,
                                             serial_control_b[0]} :
      (addr_in == `OFS_SERIAL_CONTROL_C)  ? serial_control_c :
      (addr_in == `OFS_BAUD_DIVIDER_LOW)  ? baud_divider_value[7:0] :
      (addr_in == `OFS_BAUD_DIVIDER_HIGH) ? {4'h0,
                                             baud_divider_value[11:8]} :
      (addr_in == `OFS_SERIAL_DATA_PORT)  ? (rx_complete_flag ?
                                             head[7:0] : 8'h00) :
      8'h00;

   // Control registers
   always @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
         rd_data_out           <= 8'h00;
         serial_control_b      <= `RST_SERIAL_CONTROL_B;
         serial_control_c      <= `RST_SERIAL_CONTROL_C;
         baud_divider_value    <= `RST_BAUD_DIVIDER;
         double_speed_select   <= 1'b0;
         multiproc_filter_mode <= 1'b0;
      end else begin
         if (rd_en_in) begin
            rd_data_out <= next_rd_data;
         end
         if (wr_en_in) begin
            if (addr_in == `OFS_SERIAL_STATUS_A) begin
               double_speed_select   <= wr_data_in[`BIT_DOUBLE_SPEED];
               multiproc_filter_mode <= wr_data_in[`BIT_MULTIPROC];
            end else if (addr_in == `OFS_SERIAL_CONTROL_B) begin
               serial_control_b <= {wr_data_in[7:2], 1'b0, wr_data_in[0]};
            end else if (addr_in == `OFS_SERIAL_CONTROL_C) begin
               serial_control_c <= wr_data_in;
            end else if (addr_in == `OFS_BAUD_DIVIDER_LOW) begin
               baud_divider_value[7:0] <= wr_data_in;
            end else if (addr_in == `OFS_BAUD_DIVIDER_HIGH) begin
               baud_divider_value[11:8] <= wr_data_in[3:0];
            end
         end
      end
   end

   // Baud divider: one tick every divider plus one clocks
   always @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
         baud_cnt <= 12'h000;
         tick     <= 1'b0;
      end else if (baud_cnt == 12'h000) begin
         baud_cnt <= baud_divider_value;
         tick     <= 1'b1;
      end else begin
         baud_cnt <= baud_cnt - 12'h001;
         tick     <= 1'b0;
      end
   end

   // Receiver
   assign rx_start = (rx_state == R_IDLE) & rx_en & tick & ~rx_sync;
   assign rx_par_calc = ^rx_shift ^ serial_control_c[`BIT_PARITY_ODD];
   assign is_addr  = (nbits == 4'h9) & rx_shift[8];
   assign rx_push  = (rx_state == R_DONE) &
                     ~(multiproc_filter_mode & ~spi_mode & ~is_addr);

   always @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
         rx_state   <= R_IDLE;
         rx_sc      <= 5'h00;
         rx_pos     <= 4'h0;
         rx_shift   <= 9'h000;
         rx_par_err <= 1'b0;
         rx_frm_err <= 1'b0;
      end else if (!rx_en) begin
         rx_state <= R_IDLE;
      end else begin
         case (rx_state)
            R_IDLE: begin
               if (rx_start) begin
                  rx_state   <= R_RECV;
                  rx_sc      <= {1'b0, spb[4:1]} - 5'h01;
                  rx_pos     <= 4'h0;
                  rx_shift   <= 9'h000;
                  rx_par_err <= 1'b0;
               end
            end
            R_RECV: begin
               if (tick) begin
                  if (rx_sc != 5'h00) begin
                     rx_sc <= rx_sc - 5'h01;
                  end else begin
                     rx_sc  <= spb - 5'h01;
                     rx_pos <= rx_pos + 4'h1;
                     if (rx_pos == 4'h0) begin
                        if (rx_sync) begin
                           rx_state <= R_IDLE;
                        end
                     end else if (rx_pos <= nbits) begin
                        rx_shift[rx_pos - 4'h1] <= rx_sync;
                     end else if (par_en && rx_pos == nbits + 4'h1) begin
                        rx_par_err <= rx_par_calc ^ rx_sync;
                     end else begin
                        rx_frm_err <= ~rx_sync;
                        rx_state   <= R_DONE;
                     end
                     if (rx_pos == rx_last && rx_pos != 4'h0) begin
                        rx_frm_err <= ~rx_sync;
                        rx_state   <= R_DONE;
                     end
                  end
               end
            end
            R_DONE: begin
               rx_state <= R_IDLE;
            end
            default: begin
               rx_state <= R_IDLE;
            end
         endcase
      end
   end

   // Receive FIFO, hold stage and overrun
   always @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
         fifo_wr_ptr   <= 1'b0;
         fifo_rd_ptr   <= 1'b0;
         fifo_count    <= 2'h0;
         rx_hold       <= 11'h000;
         rx_hold_valid <= 1'b0;
         overrun_flag  <= 1'b0;
      end else if (!rx_en) begin
         fifo_wr_ptr   <= 1'b0;
         fifo_rd_ptr   <= 1'b0;
         fifo_count    <= 2'h0;
         rx_hold_valid <= 1'b0;
         overrun_flag  <= 1'b0;
      end else begin
         if (rx_push && !rx_hold_valid) begin
            rx_hold       <= {rx_frm_err, rx_par_err & par_en, rx_shift};
            rx_hold_valid <= 1'b1;
         end else if (rx_hold_valid && (fifo_count != 2'h2 || pop)) begin
            fifo_mem[fifo_wr_ptr] <= rx_hold;
            fifo_wr_ptr   <= ~fifo_wr_ptr;
            rx_hold_valid <= 1'b0;
         end
         if (rx_hold_valid && (fifo_count != 2'h2 || pop)) begin
            if (!pop) begin
               fifo_count <= fifo_count + 2'h1;
            end
         end else if (pop) begin
            fifo_count <= fifo_count - 2'h1;
         end
         if (pop) begin
            fifo_rd_ptr <= ~fifo_rd_ptr;
         end
         if (rx_start && fifo_count == 2'h2 && rx_hold_valid) begin
            overrun_flag <= 1'b1;
         end else if (pop) begin
            overrun_flag <= 1'b0;
         end
      end
   end

   // Transmit buffer, drops writes while full
   assign tx_load = (tx_state == T_IDLE) & tx_en & tx_buf_valid;
   assign tx_end  = (tx_state == T_SEND) & tick & (tx_sc == 5'h00) &
                    (tx_pos == tx_last);
   assign tx_par  = ^tx_shift ^ serial_control_c[`BIT_PARITY_ODD];
   assign tx_bit  = (tx_pos == 4'h0) ? 1'b0 :
                    (tx_pos <= nbits) ? tx_shift[tx_pos - 4'h1] :
                    (par_en && tx_pos == nbits + 4'h1) ? tx_par :
                    1'b1;

   always @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
         transmit_buffer <= {1'b0, `RST_SERIAL_DATA_PORT};
         tx_buf_valid    <= 1'b0;
      end else begin
         if (wr_data && tx_buffer_empty_flag) begin
            transmit_buffer <= {serial_control_b[`BIT_TX_NINTH],
                                wr_data_in};
            tx_buf_valid    <= 1'b1;
         end else if (tx_load) begin
            tx_buf_valid <= 1'b0;
         end
      end
   end

   // Transmitter shifter
   always @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
         tx_state                <= T_IDLE;
         tx_shift                <= 9'h000;
         tx_sc                   <= 5'h00;
         tx_pos                  <= 4'h0;
         tx_stop2                <= 1'b0;
         serial_transmit_pin_out <= 1'b1;
         tx_drive_out            <= 1'b0;
      end else begin
         tx_drive_out <= tx_en | (tx_state != T_IDLE) | tx_buf_valid;
         case (tx_state)
            T_IDLE: begin
               serial_transmit_pin_out <= 1'b1;
               if (tx_load) begin
                  tx_state <= T_SEND;
                  tx_shift <= transmit_buffer &
                              ~(9'h1FF << nbits);
                  tx_stop2 <= serial_control_c[`BIT_TWO_STOP];
                  tx_pos   <= 4'h0;
                  tx_sc    <= spb - 5'h01;
               end
            end
            T_SEND: begin
               serial_transmit_pin_out <= tx_bit;
               if (tick) begin
                  if (tx_sc != 5'h00) begin
                     tx_sc <= tx_sc - 5'h01;
                  end else if (tx_pos == tx_last) begin
                     tx_state <= T_IDLE;
                  end else begin
                     tx_sc  <= spb - 5'h01;
                     tx_pos <= tx_pos + 4'h1;
                  end
               end
            end
            default: begin
               tx_state <= T_IDLE;
            end
         endcase
      end
   end

   // Transmit complete: set wins over clear
   assign next_txc = (tx_end & ~tx_buf_valid) ? 1'b1 :
                     ((wr_status & wr_data_in[`BIT_TX_COMPLETE]) |
                      tx_complete_irq_ack_in) ? 1'b0 :
                     tx_complete_flag;

   // Interrupt requests
   always @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
         tx_complete_flag    <= 1'b0;
         rx_complete_irq_out <= 1'b0;
         tx_complete_irq_out <= 1'b0;
         tx_empty_irq_out    <= 1'b0;
      end else begin
         tx_complete_flag    <= next_txc;
         rx_complete_irq_out <= global_irq_enable_in & rx_complete_flag &
                                serial_control_b[`BIT_RX_IRQ_EN];
         tx_complete_irq_out <= global_irq_enable_in & tx_complete_flag &
                                serial_control_b[`BIT_TX_IRQ_EN];
         tx_empty_irq_out    <= global_irq_enable_in & tx_buffer_empty_flag &
                                serial_control_b[`BIT_EMPTY_IRQ_EN];
      end
   end
endmodule
`default_nettype wire

// file: rtl/uart_data_and_status_regs.vh
`ifndef UART_DATA_AND_STATUS_REGS_VH
`define UART_DATA_AND_STATUS_REGS_VH
// Register offsets
`define OFS_SERIAL_STATUS_A    8'hC0
`define OFS_SERIAL_CONTROL_B   8'hC1
`define OFS_SERIAL_CONTROL_C   8'hC2
`define OFS_BAUD_DIVIDER_LOW   8'hC4
`define OFS_BAUD_DIVIDER_HIGH  8'hC5
`define OFS_SERIAL_DATA_PORT   8'hC6
// Reset values
`define RST_SERIAL_STATUS_A    8'h20
`define RST_SERIAL_CONTROL_B   8'h00
`define RST_SERIAL_CONTROL_C   8'h06
`define RST_SERIAL_DATA_PORT   8'h00
`define RST_BAUD_DIVIDER       12'h000
// Status A fields
`define BIT_RX_COMPLETE        7
`define BIT_TX_COMPLETE        6
`define BIT_TX_BUFFER_EMPTY    5
`define BIT_FRAME_ERROR        4
`define BIT_OVERRUN            3
`define BIT_PARITY_ERROR       2
`define BIT_DOUBLE_SPEED       1
`define BIT_MULTIPROC          0
// Control B fields
`define BIT_RX_IRQ_EN          7
`define BIT_TX_IRQ_EN          6
`define BIT_EMPTY_IRQ_EN       5
`define BIT_RX_ENABLE          4
`define BIT_TX_ENABLE          3
`define BIT_SIZE_HIGH          2
`define BIT_RX_NINTH           1
`define BIT_TX_NINTH           0
// Control C fields
`define BIT_MODE_HIGH          7
`define BIT_MODE_LOW           6
`define BIT_PARITY_ENABLE      5
`define BIT_PARITY_ODD         4
`define BIT_TWO_STOP           3
`define BIT_SIZE_MID           2
`define BIT_SIZE_LOW           1
// Mode codes and timing counts
`define MODE_ASYNC             2'h0
`define MODE_MASTER_SPI        2'h3
`define SAMPLES_NORMAL         5'h10
`define SAMPLES_DOUBLE         5'h08
`endif

// file: tb/remote_station.sv
`timescale 1ns/1ps
`default_nettype none
module remote_station (
   input  wire logic clock_in,
   input  wire logic line_in,
   output var  logic line_out
);
   initial line_out = 1'b1;
   // One frame out, LSB first, line back to idle high
   task automatic send(input logic [8:0] dat, input int nb, input logic stp,
                       input int bc);
      line_out <= 1'b0;
      repeat (bc) @(posedge clock_in);
      for (int i = 0; i < nb; i++) begin
         line_out <= dat[i];
         repeat (bc) @(posedge clock_in);
      end
      line_out <= stp;
      repeat (bc) @(posedge clock_in);
      line_out <= 1'b1;
      @(posedge clock_in);
   endtask
   // One frame in, sampled mid-bit
   task automatic get(output logic [7:0] dat, output logic stp,
                      input int nb, input int bc);
      int n;
      dat = 8'h00;
      n = 0;
      while (line_in === 1'b1 && n < 3000) begin
         @(posedge clock_in);
         n++;
      end
      repeat (bc / 2) @(posedge clock_in);
      for (int i = 0; i < nb; i++) begin
         repeat (bc) @(posedge clock_in);
         dat[i] = line_in;
      end
      repeat (bc) @(posedge clock_in);
      stp = line_in;
   endtask
endmodule
`default_nettype wire

// file: tb/uart_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module uart_regs_props (
   input wire logic       clock_in,
   input wire logic       rstn_in,
   input wire logic [7:0] addr_in,
   input wire logic       wr_en_in,
   input wire logic       rd_en_in,
   input wire logic [7:0] rd_data_out,
   input wire logic       serial_transmit_pin_out,
   input wire logic       tx_drive_out,
   input wire logic       global_irq_enable_in,
   input wire logic       tx_complete_irq_ack_in,
   input wire logic       rx_complete_irq_out,
   input wire logic       tx_complete_irq_out,
   input wire logic       tx_empty_irq_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rstn_in);
   sequence s_data_write;
      wr_en_in && addr_in == 8'hC6;
   endsequence
   sequence s_status_read;
      rd_en_in && addr_in == 8'hC0;
   endsequence
   property p_unmapped_read;
      rd_en_in && !(addr_in inside {8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC5,
         8'hC6}) |=> rd_data_out == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not zero");
   property p_irq_gate;
      !global_irq_enable_in |=> !rx_complete_irq_out && !tx_complete_irq_out
         && !tx_empty_irq_out;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("request without global enable");
   property p_pin_needs_drive;
      !serial_transmit_pin_out |-> tx_drive_out;
   endproperty
   a_pin_needs_drive: assert property (p_pin_needs_drive)
      else $error("line low while not driven");
   property p_bit_min_len;
      $changed(serial_transmit_pin_out) |=> $stable(serial_transmit_pin_out)[*7];
   endproperty
   a_bit_min_len: assert property (p_bit_min_len)
      else $error("bit shorter than eight clocks");
   property p_ack_clears;
      tx_complete_irq_ack_in && !tx_drive_out |=> ##1 !tx_complete_irq_out;
   endproperty
   a_ack_clears: assert property (p_ack_clears)
      else $error("ack left tx complete set");
   property p_write_fills;
      s_data_write ##1 s_status_read |=> !rd_data_out[5];
   endproperty
   a_write_fills: assert property (p_write_fills)
      else $error("buffer empty after data write");
   property p_empty_irq_drop;
      s_data_write |=> ##1 !tx_empty_irq_out;
   endproperty
   a_empty_irq_drop: assert property (p_empty_irq_drop)
      else $error("empty request stayed after write");
   property p_reset_quiet;
      $rose(rstn_in) |-> (serial_transmit_pin_out && !tx_drive_out &&
         !tx_empty_irq_out)[*2];
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active during reset release");
endmodule
bind uart_data_and_status_regs uart_regs_props u_props (
   .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
   .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
   .serial_transmit_pin_out(serial_transmit_pin_out),
   .tx_drive_out(tx_drive_out), .global_irq_enable_in(global_irq_enable_in),
   .tx_complete_irq_ack_in(tx_complete_irq_ack_in),
   .rx_complete_irq_out(rx_complete_irq_out),
   .tx_complete_irq_out(tx_complete_irq_out),
   .tx_empty_irq_out(tx_empty_irq_out));
`default_nettype wire

// file: tb/tb_uart_data_and_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_uart_data_and_status_regs;
   logic       clock_in, rstn_in, wr_en_in, rd_en_in, irq_en, ack, s;
   logic [7:0] addr_in, wr_data_in, rd_data_out, d;
   logic       to_dut, from_dut, drive, rx_irq, tx_irq, empty_irq;
   int         n_mismatch, cmp_count, cycles;
   uart_data_and_status_regs uut (
      .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .serial_receive_pin_in(to_dut),
      .serial_transmit_pin_out(from_dut), .tx_drive_out(drive),
      .global_irq_enable_in(irq_en), .tx_complete_irq_ack_in(ack),
      .rx_complete_irq_out(rx_irq), .tx_complete_irq_out(tx_irq),
      .tx_empty_irq_out(empty_irq));
   remote_station peer (.clock_in(clock_in), .line_in(from_dut),
      .line_out(to_dut));
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         finish_test;
      end
   end
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, dat);
      wr_en_in <= w;
      rd_en_in <= !w;
      addr_in <= a;
      wr_data_in <= dat;
      @(posedge clock_in);
   endtask
   task automatic idle(input int n);
      wr_en_in <= 1'b0;
      rd_en_in <= 1'b0;
      repeat (n) @(posedge clock_in);
   endtask
   task automatic wr(input logic [7:0] a, dat);
      bus(1'b1, a, dat);
      idle(1);
   endtask
   // Plain reads only, never read-modify-write on the data port
   task automatic rd(input string nm, input logic [7:0] a, exp);
      bus(1'b0, a, 8'h00);
      wr_en_in <= 1'b0;
      rd_en_in <= 1'b0;
      #1 chk(nm, exp, rd_data_out);
      @(posedge clock_in);
   endtask
   task automatic t_reset;
      rd("status", 8'hC0, 8'h20);
      rd("data", 8'hC6, 8'h00);
      rd("unmapped", 8'hC3, 8'h00);
      rd("status", 8'hC0, 8'h20);
      $display("reset test done");
   endtask
   task automatic t_tx;
      bus(1'b1, 8'hC6, 8'hA5);
      bus(1'b1, 8'hC6, 8'h5A);
      rd("busy", 8'hC0, 8'h00);
      wr(8'hC1, 8'h08);
      peer.get(d, s, 8, 16);
      chk("tx byte", 8'hA5, d);
      idle(20);
      rd("done", 8'hC0, 8'h60);
      wr(8'hC0, 8'h40);
      rd("cleared", 8'hC0, 8'h20);
      $display("transmit test done");
   endtask
   task automatic t_irq;
      wr(8'hC1, 8'h68);
      irq_en <= 1'b1;
      idle(3);
      chk("empty irq", 8'h01, {7'h0, empty_irq});
      wr(8'hC6, 8'h0F);
      peer.get(d, s, 8, 16);
      idle(20);
      chk("done irq", 8'h01, {7'h0, tx_irq});
      irq_en <= 1'b0;
      idle(3);
      chk("gated", 8'h00, {6'h0, tx_irq, empty_irq});
      irq_en <= 1'b1;
      wr(8'hC1, 8'h40);
      idle(3);
      ack <= 1'b1;
      idle(1);
      ack <= 1'b0;
      idle(3);
      chk("acked", 8'h00, {7'h0, tx_irq});
      irq_en <= 1'b0;
      $display("interrupt test done");
   endtask
   task automatic t_rx;
      wr(8'hC1, 8'h90);
      irq_en <= 1'b1;
      peer.send(8'h3C, 8, 1'b1, 16);
      peer.send(8'hC3, 8, 1'b0, 16);
      idle(40);
      chk("rx irq", 8'h01, {7'h0, rx_irq});
      rd("two", 8'hC0, 8'hA0);
      rd("first", 8'hC6, 8'h3C);
      rd("ferr", 8'hC0, 8'hB0);
      rd("second", 8'hC6, 8'hC3);
      rd("empty", 8'hC0, 8'h20);
      irq_en <= 1'b0;
      for (int i = 1; i < 5; i++)
         peer.send(8'(8'h11 * i), 8, 1'b1, 16);
      idle(40);
      rd("overrun", 8'hC0, 8'hA8);
      for (int i = 1; i < 4; i++)
         rd("fifo", 8'hC6, 8'(8'h11 * i));
      rd("drained", 8'hC0, 8'h20);
      peer.send(8'h55, 8, 1'b1, 16);
      idle(40);
      wr(8'hC1, 8'h00);
      wr(8'hC1, 8'h10);
      rd("flushed", 8'hC0, 8'h20);
      $display("receive test done");
   endtask
   task automatic t_size;
      wr(8'hC2, 8'h00);
      wr(8'hC1, 8'h18);
      peer.send(8'hFF, 5, 1'b1, 16);
      idle(40);
      rd("rx five", 8'hC6, 8'h1F);
      wr(8'hC6, 8'h40);
      peer.get(d, s, 5, 16);
      chk("tx five", 8'h80, {s, d[6:0]});
      idle(20);
      wr(8'hC0, 8'h40);
      wr(8'hC2, 8'h20);
      peer.send(8'h01, 6, 1'b1, 16);
      idle(40);
      rd("perr", 8'hC0, 8'hA4);
      rd("pdata", 8'hC6, 8'h01);
      wr(8'hC2, 8'h06);
      $display("size test done");
   endtask
   task automatic t_speed;
      wr(8'hC0, 8'h02);
      rd("dbl", 8'hC0, 8'h22);
      wr(8'hC6, 8'h96);
      peer.get(d, s, 8, 8);
      chk("fast byte", 8'h96, d);
      idle(12);
      wr(8'hC0, 8'h42);
      wr(8'hC2, 8'hC0);
      rd("spi", 8'hC0, 8'h20);
      wr(8'hC2, 8'h06);
      rd("async", 8'hC0, 8'h22);
      wr(8'hC0, 8'h01);
      peer.send(8'h5A, 8, 1'b1, 16);
      idle(40);
      rd("filtered", 8'hC0, 8'h21);
      wr(8'hC1, 8'h1C);
      peer.send(9'h1A5, 9, 1'b1, 16);
      idle(40);
      rd("ninth", 8'hC1, 8'h1E);
      rd("addr", 8'hC6, 8'hA5);
      wr(8'hC1, 8'h18);
      wr(8'hC0, 8'h00);
      wr(8'hC4, 8'h01);
      wr(8'hC6, 8'hC5);
      peer.get(d, s, 8, 32);
      chk("slow byte", 8'hC5, d);
      idle(40);
      wr(8'hC4, 8'h00);
      $display("speed and filter test done");
   endtask
   initial begin
      rstn_in = 1'b0;
      wr_en_in = 1'b0;
      rd_en_in = 1'b0;
      addr_in = 8'h00;
      wr_data_in = 8'h00;
      irq_en = 1'b0;
      ack = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (20) @(posedge clock_in);
      rstn_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      t_reset;
      t_tx;
      t_irq;
      t_rx;
      t_size;
      t_speed;
      finish_test;
   end
endmodule
`default_nettype wire
